// File: rtl/cfg_word_reg.sv
/*
 * holds one 24-bit read/write configuration word with a reset value.
 * assumes write strobe and data come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_word_reg
   import pll_regs_pkg::*;
#(
   parameter logic [23:0] RST_VAL = 24'h000000
)
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        wr_en,
   input  wire logic [23:0] wr_data,
   output logic      [23:0] word
);

   logic [23:0] word_ff;
   logic [23:0] nxt_word;

   // a write replaces the whole word; no bit is masked or forced
   always_comb
   begin
      nxt_word = word_ff;
      if (wr_en)
      begin
         nxt_word = wr_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         word_ff <= RST_VAL;
      end
      else
      begin
         word_ff <= nxt_word;
      end
   end

   assign word = word_ff;

endmodule

`default_nettype wire

// File: rtl/pad_release_ctrl.sv
/*
 * drives the lock-detect / serial-data pad: off, always driven, or
 * released while a foreign chip address owns the shared serial bus.
 * assumes address match and mismatch pulses come from the serial decoder
 * on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pad_release_ctrl
   import pll_regs_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic pad_on,
   input  wire logic gpo_always,
   input  wire logic addr_mismatch,
   input  wire logic addr_match,
   input  wire logic pad_data,
   output logic      pin_o,
   output logic      pin_oe,
   output logic      released
);

   pad_state_t state_ff;
   pad_state_t nxt_state;
   logic       pin_o_ff;
   logic       nxt_pin_o;
   logic       pin_oe_ff;
   logic       nxt_pin_oe;
   logic       released_ff;
   logic       nxt_released;

   // mismatch beats a match in the same cycle so a foreign frame is never
   // driven over while gpo_always is clear
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         PAD_OFF:
         begin
            if (pad_on)
               nxt_state = PAD_DRIVE;
         end
         PAD_DRIVE:
         begin
            if (!pad_on)
               nxt_state = PAD_OFF;
            else if (!gpo_always && addr_mismatch)
               nxt_state = PAD_RELEASED;
         end
         PAD_RELEASED:
         begin
            if (!pad_on)
               nxt_state = PAD_OFF;
            else if (gpo_always)
               nxt_state = PAD_DRIVE;
            else if (addr_match && !addr_mismatch)
               nxt_state = PAD_DRIVE;
         end
         default:
         begin
            nxt_state = PAD_OFF;
         end
      endcase
      nxt_pin_oe   = (nxt_state == PAD_DRIVE);
      nxt_released = (nxt_state == PAD_RELEASED);
      nxt_pin_o  = nxt_pin_oe & pad_data;
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state_ff  <= PAD_OFF;
         pin_o_ff  <= 1'b0;
         pin_oe_ff <= 1'b0;
         released_ff <= 1'b0;
      end
      else
      begin
         state_ff  <= nxt_state;
         pin_o_ff  <= nxt_pin_o;
         pin_oe_ff <= nxt_pin_oe;
         released_ff <= nxt_released;
      end
   end

   assign pin_o    = pin_o_ff;
   assign pin_oe   = pin_oe_ff;
   // registered copy of the state so the top output comes from a flop
   assign released = released_ff;

endmodule

`default_nettype wire

// File: rtl/pll_enable_and_pump_regs.sv
/*
 * analog enable and charge-pump configuration registers of the synthesizer,
 * with the pad control of the lock-detect / serial-data pin and the decoded
 * pump currents.
 * assumes a serial control port decoder on core_clk delivering one-cycle
 * write and read strobes with a register index, plus chip address match
 * and mismatch pulses; the far-side gpo select bit comes from the pad
 * configuration register elsewhere on the same clock.
 */
// What this block does
// - bits 0-4 enable bias, pump, phase detector, reference and RF buffers; reset 1.
// - a cleared pad enable bit turns the lock/serial output pin off.
// - pad enabled with gpo select set drives the pin continuously.
// - pad enabled, gpo select clear: release pin on foreign chip address.
// - bit 7 gates the divider clock into digital logic; reset 1.
// - bit 9 prescaler clock, bit 10 buffer and prescaler bias; reset 1.
// - down gain code in bits 6:0, 20 uA steps, reset 100.
// - up gain code in bits 13:7, 20 uA steps, reset 100.
// - offset magnitude in bits 20:14, 5 uA steps, reset 0.
// - bit 23 selects high-current pump mode; reset 0.
`timescale 1ns/1ps
`default_nettype none

module pll_enable_and_pump_regs
   import pll_regs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [23:0] wr_data,
   input  wire logic        gpo_always,
   input  wire logic        addr_mismatch,
   input  wire logic        addr_match,
   input  wire logic        pad_data,
   output logic      [23:0] rd_data,
   output logic             rd_valid,
   output logic             rd_unmapped,
   output analog_en_t       analog_en,
   output pump_cfg_t        pump_cfg,
   output logic             lock_serial_out_pin_o,
   output logic             lock_serial_out_pin_oe,
   output logic             pad_released,
   output logic      [11:0] pump_down_ua,
   output logic      [11:0] pump_up_ua,
   output logic      [9:0]  offset_up_ua,
   output logic      [9:0]  offset_down_ua
);

   // ****************************************************************
   // address decode
   // ****************************************************************

   logic        hit_analog;
   logic        hit_pump;
   logic        wr_analog;
   logic        wr_pump;
   logic [23:0] analog_word;
   logic [23:0] pump_word;

   // writes to any other index are dropped silently
   assign hit_analog = (reg_addr == ANALOG_ENABLE_CONTROLS_IDX);
   assign hit_pump   = (reg_addr == PUMP_CURRENT_SETTINGS_IDX);
   assign wr_analog  = wr_stb & hit_analog;
   assign wr_pump    = wr_stb & hit_pump;

   // ****************************************************************
   // configuration words
   // ****************************************************************

   // software keeps the reserved and amplifier bits at their required
   // values; hardware stores whatever is written so readback stays honest
   cfg_word_reg #(
      .RST_VAL (ANALOG_ENABLE_CONTROLS_RST)
   ) u_analog_word (
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr_en    (wr_analog),
      .wr_data  (wr_data),
      .word     (analog_word)
   );

   cfg_word_reg #(
      .RST_VAL (PUMP_CURRENT_SETTINGS_RST)
   ) u_pump_word (
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr_en    (wr_pump),
      .wr_data  (wr_data),
      .word     (pump_word)
   );

   // ****************************************************************
   // field view of the words
   // ****************************************************************

   analog_en_t analog_fields;
   pump_cfg_t  pump_fields;

   // the struct layout places every enable at its fixed bit position
   assign analog_fields = analog_en_t'(analog_word);
   assign pump_fields   = pump_cfg_t'(pump_word);

   // the register flops themselves feed the analog sub-blocks
   assign analog_en = analog_fields;
   assign pump_cfg  = pump_fields;

   // ****************************************************************
   // read port
   // ****************************************************************

   logic [23:0] rd_data_ff;
   logic [23:0] nxt_rd_data;
   logic        rd_valid_ff;
   logic        nxt_rd_valid;
   logic        rd_unmapped_ff;
   logic        nxt_rd_unmapped;

   // answer comes one cycle after the strobe; unmapped indices read zero
   // and are flagged so the serial side can tell them from a real zero
   always_comb
   begin
      nxt_rd_valid    = rd_stb;
      nxt_rd_unmapped = 1'b0;
      nxt_rd_data     = rd_data_ff;
      if (rd_stb)
      begin
         if (hit_analog)
            nxt_rd_data = analog_word;
         else if (hit_pump)
            nxt_rd_data = pump_word;
         else
         begin
            nxt_rd_data     = 24'h000000;
            nxt_rd_unmapped = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         rd_data_ff     <= 24'h000000;
         rd_valid_ff    <= 1'b0;
         rd_unmapped_ff <= 1'b0;
      end
      else
      begin
         rd_data_ff     <= nxt_rd_data;
         rd_valid_ff    <= nxt_rd_valid;
         rd_unmapped_ff <= nxt_rd_unmapped;
      end
   end

   assign rd_data     = rd_data_ff;
   assign rd_valid    = rd_valid_ff;
   assign rd_unmapped = rd_unmapped_ff;

   // ****************************************************************
   // lock-detect / serial-data pad
   // ****************************************************************

   // the pad enable comes straight from the live register bit so a write
   // takes effect on the pin within two cycles
   pad_release_ctrl u_pad (
      .core_clk      (core_clk),
      .resetn        (resetn),
      .pad_on        (analog_fields.pad_on),
      .gpo_always    (gpo_always),
      .addr_mismatch (addr_mismatch),
      .addr_match    (addr_match),
      .pad_data      (pad_data),
      .pin_o         (lock_serial_out_pin_o),
      .pin_oe        (lock_serial_out_pin_oe),
      .released      (pad_released)
   );

   // ****************************************************************
   // decoded pump currents
   // ****************************************************************

   logic [11:0] pump_down_ua_ff;
   logic [11:0] nxt_pump_down_ua;
   logic [11:0] pump_up_ua_ff;
   logic [11:0] nxt_pump_up_ua;
   logic [9:0]  offset_up_ua_ff;
   logic [9:0]  nxt_offset_up_ua;
   logic [9:0]  offset_down_ua_ff;
   logic [9:0]  nxt_offset_down_ua;
   logic [9:0]  offset_mag_ua;

   // largest code 127 gives 2540 uA and 635 uA, so 12 and 10 bits suffice;
   // the pump currents drop to zero while the pump itself is disabled
   always_comb
   begin
      offset_mag_ua    = {3'b000, pump_fields.offset_mag} * OFFSET_STEP_UA;
      nxt_pump_down_ua = 12'h000;
      nxt_pump_up_ua   = 12'h000;
      if (analog_fields.pump_on)
      begin
         nxt_pump_down_ua = {5'b00000, pump_fields.pump_down_gain} * GAIN_STEP_UA;
         nxt_pump_up_ua   = {5'b00000, pump_fields.pump_up_gain} * GAIN_STEP_UA;
      end
      nxt_offset_up_ua   = pump_fields.offset_up_on ? offset_mag_ua : 10'h000;
      nxt_offset_down_ua = pump_fields.offset_down_on ? offset_mag_ua : 10'h000;
      if (!analog_fields.pump_on)
      begin
         nxt_offset_up_ua   = 10'h000;
         nxt_offset_down_ua = 10'h000;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         pump_down_ua_ff   <= 12'h000;
         pump_up_ua_ff     <= 12'h000;
         offset_up_ua_ff   <= 10'h000;
         offset_down_ua_ff <= 10'h000;
      end
      else
      begin
         pump_down_ua_ff   <= nxt_pump_down_ua;
         pump_up_ua_ff     <= nxt_pump_up_ua;
         offset_up_ua_ff   <= nxt_offset_up_ua;
         offset_down_ua_ff <= nxt_offset_down_ua;
      end
   end

   assign pump_down_ua   = pump_down_ua_ff;
   assign pump_up_ua     = pump_up_ua_ff;
   assign offset_up_ua   = offset_up_ua_ff;
   assign offset_down_ua = offset_down_ua_ff;

endmodule

`default_nettype wire

// File: rtl/pll_regs_pkg.sv
/*
 * holds the register map, field layouts, reset values and current scale
 * steps of the synthesizer enable and charge-pump configuration registers.
 * assumes the serial control port decoder delivers word-wide accesses with
 * the register index on the address lines.
 */
`default_nettype none

package pll_regs_pkg;

   // ****************************************************************
   // register port geometry
   // ****************************************************************
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 24;

   // register indices as seen on the serial control port
   localparam logic [5:0] ANALOG_ENABLE_CONTROLS_IDX = 6'h08;
   localparam logic [5:0] PUMP_CURRENT_SETTINGS_IDX  = 6'h09;

   // values after reset
   localparam logic [23:0] ANALOG_ENABLE_CONTROLS_RST = 24'hc1beff;
   localparam logic [23:0] PUMP_CURRENT_SETTINGS_RST  = 24'h403264;

   // ****************************************************************
   // analog enable register, bit 23 first
   // ****************************************************************
   typedef struct packed {
      logic       rsv_23;             // keep at 1
      logic       rsv_22;             // keep at 1
      logic       high_freq_ref;      // set for a crystal above 200 MHz
      logic       rsv_20;             // keep at 0
      logic       rsv_19;
      logic       spare_18;
      logic [2:0] rsv_17_15;
      logic [2:0] rsv_14_12;
      logic       pump_amp_on;        // keep at 1
      logic       vco_presc_bias_on;
      logic       presc_clock_on;
      logic       rsv_8;
      logic       divider_clock_gate;
      logic       rsv_6;
      logic       pad_on;
      logic       vco_rf_buf_on;
      logic       ref_buf_on;
      logic       phase_detector_on;
      logic       pump_on;
      logic       bias_on;
   } analog_en_t;

   // ****************************************************************
   // charge-pump register, bit 23 first
   // ****************************************************************
   typedef struct packed {
      logic       high_current_pump;
      logic       offset_down_on;
      logic       offset_up_on;
      logic [6:0] offset_mag;
      logic [6:0] pump_up_gain;
      logic [6:0] pump_down_gain;
   } pump_cfg_t;

   // field positions of the charge-pump codes
   localparam int unsigned PUMP_DOWN_LSB  = 0;
   localparam int unsigned PUMP_UP_LSB    = 7;
   localparam int unsigned OFFSET_MAG_LSB = 14;

   // current per code step, in microamps
   localparam logic [11:0] GAIN_STEP_UA   = 12'h014;
   localparam logic [9:0]  OFFSET_STEP_UA = 10'h005;

   // ****************************************************************
   // pad drive state
   // ****************************************************************
   typedef enum logic [1:0] {
      PAD_OFF,
      PAD_DRIVE,
      PAD_RELEASED
   } pad_state_t;

endpackage

`default_nettype wire

// File: tb/pll_regs_asserts.sv
/*
 * port checks for the enable and charge-pump register block.
 * assumes one clock, core_clk, and a synchronous active-low resetn.
 */
`timescale 1ns/1ps
`default_nettype none

module pll_regs_asserts
   import pll_regs_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [5:0]  reg_addr,
   input wire logic [23:0] wr_data,
   input wire logic        gpo_always,
   input wire logic        addr_mismatch,
   input wire logic        addr_match,
   input wire logic        pad_data,
   input wire logic [23:0] rd_data,
   input wire logic        rd_valid,
   input wire logic        rd_unmapped,
   input wire analog_en_t  analog_en,
   input wire pump_cfg_t   pump_cfg,
   input wire logic        lock_serial_out_pin_o,
   input wire logic        lock_serial_out_pin_oe,
   input wire logic        pad_released,
   input wire logic [11:0] pump_down_ua,
   input wire logic [11:0] pump_up_ua,
   input wire logic [9:0]  offset_down_ua
);
   // ****************************************************************
   // pad events
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // foreign address while the pad is driven on a shared bus
   sequence foreign_seen;
      analog_en.pad_on && lock_serial_out_pin_oe && !gpo_always && addr_mismatch;
   endsequence
   // own address ends the release; a mismatch in the same cycle wins
   sequence own_seen;
      pad_released && analog_en.pad_on && !gpo_always && addr_match && !addr_mismatch;
   endsequence

   // ****************************************************************
   // assertions
   // ****************************************************************
   reset_value_a: assert property ($rose(resetn) |->
      analog_en == ANALOG_ENABLE_CONTROLS_RST && pump_cfg == PUMP_CURRENT_SETTINGS_RST)
      else $error("register default missing after reset");
   ae_write_a: assert property (wr_stb && reg_addr == ANALOG_ENABLE_CONTROLS_IDX
      |=> analog_en == $past(wr_data)) else $error("analog enable write lost");
   ae_read_a: assert property (rd_stb && reg_addr == ANALOG_ENABLE_CONTROLS_IDX
      |=> rd_valid && rd_data == $past(analog_en)) else $error("analog enable readback wrong");
   unmapped_read_a: assert property (rd_stb && reg_addr != ANALOG_ENABLE_CONTROLS_IDX
      && reg_addr != PUMP_CURRENT_SETTINGS_IDX |=> rd_valid && rd_unmapped && rd_data == 0)
      else $error("unmapped read not flagged");
   pad_off_a: assert property (!analog_en.pad_on [*3] |->
      !lock_serial_out_pin_oe && !lock_serial_out_pin_o) else $error("pin driven while off");
   gpo_drive_a: assert property ((analog_en.pad_on && gpo_always) [*3] |->
      lock_serial_out_pin_oe && !pad_released) else $error("gpo pin not driven");
   pin_data_a: assert property (lock_serial_out_pin_oe && $past(lock_serial_out_pin_oe)
      |-> lock_serial_out_pin_o == $past(pad_data)) else $error("pin data wrong");
   release_a: assert property (foreign_seen |=> pad_released && !lock_serial_out_pin_oe)
      else $error("pin kept on foreign address");
   rejoin_a: assert property (own_seen |=> !pad_released && lock_serial_out_pin_oe)
      else $error("pin not retaken on own address");
   gain_ua_a: assert property (analog_en.pump_on |=>
      pump_down_ua == $past(pump_cfg.pump_down_gain) * GAIN_STEP_UA
      && pump_up_ua == $past(pump_cfg.pump_up_gain) * GAIN_STEP_UA)
      else $error("gain current wrong");
   offset_ua_a: assert property (analog_en.pump_on && pump_cfg.offset_down_on |=>
      offset_down_ua == $past(pump_cfg.offset_mag) * OFFSET_STEP_UA)
      else $error("offset current wrong");
endmodule

bind pll_enable_and_pump_regs pll_regs_asserts u_chk (.core_clk, .resetn, .wr_stb, .rd_stb,
   .reg_addr, .wr_data, .gpo_always, .addr_mismatch, .addr_match, .pad_data, .rd_data,
   .rd_valid, .rd_unmapped, .analog_en, .pump_cfg, .lock_serial_out_pin_o,
   .lock_serial_out_pin_oe, .pad_released, .pump_down_ua, .pump_up_ua, .offset_down_ua);

`default_nettype wire

// File: tb/test_pll_enable_and_pump_regs.sv
/*
 * self-checking bench for the enable and charge-pump register block.
 * assumes the package, the block and its checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_pll_enable_and_pump_regs
   import pll_regs_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [23:0] wr_data = 24'h000000;
   logic        gpo_always = 1'b0;
   logic        addr_mismatch = 1'b0;
   logic        addr_match = 1'b0;
   logic        pad_data = 1'b0;
   logic [23:0] rd_data;
   logic        rd_valid, rd_unmapped, lock_serial_out_pin_o, lock_serial_out_pin_oe;
   logic        pad_released;
   analog_en_t  analog_en;
   pump_cfg_t   pump_cfg;
   logic [11:0] pump_down_ua, pump_up_ua;
   logic [9:0]  offset_up_ua, offset_down_ua;
   int          mismatches = 0;
   int          n_checks = 0;

   // rows: index, written word, expected readback; analog words keep bits
   // 11, 22, 23 at 1 and bit 20 at 0, pump words keep bit 21 at 0
   localparam int ROWS = 7;
   logic [53:0] rows [ROWS] = '{{6'h08, 24'hc00800, 24'hc00800},
      {6'h08, 24'hefffff, 24'hefffff}, {6'h09, 24'h555555, 24'h555555},
      {6'h09, 24'h8aaaaa, 24'h8aaaaa}, {6'h07, 24'h123456, 24'h000000},
      {6'h0a, 24'h654321, 24'h000000}, {6'h3f, 24'hffffff, 24'h000000}};

   pll_enable_and_pump_regs DUT (.core_clk, .resetn, .wr_stb, .rd_stb, .reg_addr, .wr_data,
      .gpo_always, .addr_mismatch, .addr_match, .pad_data, .rd_data, .rd_valid,
      .rd_unmapped, .analog_en, .pump_cfg, .lock_serial_out_pin_o, .lock_serial_out_pin_oe,
      .pad_released, .pump_down_ua, .pump_up_ua, .offset_up_ua, .offset_down_ua);

   always #5 core_clk = ~core_clk;

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chkb(input string name, input logic seen, input logic exp);
      chk(name, 24'(seen), 24'(exp));
   endtask

   // strobes rise on a falling edge and drop after one taking edge
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge core_clk);
      reg_addr = a;
      wr_data = d;
      wr_stb = 1'b1;
      @(negedge core_clk);
      wr_stb = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a);
      @(negedge core_clk);
      reg_addr = a;
      rd_stb = 1'b1;
      @(negedge core_clk);
      rd_stb = 1'b0;
      chkb("rd_valid", rd_valid, 1'b1);
   endtask

   // pad needs one edge after release before it drives
   task automatic do_reset();
      resetn = 1'b0;
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      repeat (3) @(negedge core_clk);
   endtask

   task automatic check_defaults();
      chk("analog_en", analog_en, ANALOG_ENABLE_CONTROLS_RST);
      chk("pump_cfg", pump_cfg, PUMP_CURRENT_SETTINGS_RST);
      chk("pump_down_ua", 24'(pump_down_ua), 24'h0007d0);
      chk("pump_up_ua", 24'(pump_up_ua), 24'h0007d0);
      chk("offset_down_ua", 24'(offset_down_ua), 24'h000000);
      chkb("pin_oe", lock_serial_out_pin_oe, 1'b1);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************************************
   // sequence
   // ****************************************************************
   initial
   begin
      logic [5:0]  a;
      logic [23:0] d, e, ae, pc;
      logic        m;
      do_reset();
      check_defaults();
      ae = ANALOG_ENABLE_CONTROLS_RST;
      pc = PUMP_CURRENT_SETTINGS_RST;
      // unmapped writes must leave both words untouched
      for (int i = 0; i < ROWS; i++)
      begin
         {a, d, e} = rows[i];
         m = (a == ANALOG_ENABLE_CONTROLS_IDX) || (a == PUMP_CURRENT_SETTINGS_IDX);
         wr(a, d);
         if (a == ANALOG_ENABLE_CONTROLS_IDX)
            ae = d;
         if (a == PUMP_CURRENT_SETTINGS_IDX)
            pc = d;
         chk("analog_en", analog_en, ae);
         chk("pump_cfg", pump_cfg, pc);
         rd(a);
         chk("rd_data", rd_data, e);
         chkb("rd_unmapped", rd_unmapped, !m);
      end
      do_reset();
      check_defaults();
      // top down and offset codes, up code 1, both offsets and high current on
      wr(PUMP_CURRENT_SETTINGS_IDX, 24'hffc0ff);
      @(negedge core_clk);
      chk("pump_down_ua", 24'(pump_down_ua), 24'h0009ec);
      chk("pump_up_ua", 24'(pump_up_ua), 24'h000014);
      chk("offset_up_ua", 24'(offset_up_ua), 24'h00027b);
      chk("offset_down_ua", 24'(offset_down_ua), 24'h00027b);
      chkb("high_current_pump", pump_cfg.high_current_pump, 1'b1);
      wr(ANALOG_ENABLE_CONTROLS_IDX, ANALOG_ENABLE_CONTROLS_RST & ~24'h000002);
      @(negedge core_clk);
      chk("pump_down_ua", 24'(pump_down_ua), 24'h000000);
      wr(ANALOG_ENABLE_CONTROLS_IDX, ANALOG_ENABLE_CONTROLS_RST);
      // shared bus: foreign address releases, own address retakes
      pad_data = 1'b1;
      @(negedge core_clk);
      chkb("pin_o", lock_serial_out_pin_o, 1'b1);
      addr_mismatch = 1'b1;
      @(negedge core_clk);
      addr_mismatch = 1'b0;
      chkb("pin_oe", lock_serial_out_pin_oe, 1'b0);
      chkb("pad_released", pad_released, 1'b1);
      addr_match = 1'b1;
      @(negedge core_clk);
      addr_match = 1'b0;
      chkb("pin_oe", lock_serial_out_pin_oe, 1'b1);
      gpo_always = 1'b1;
      addr_mismatch = 1'b1;
      @(negedge core_clk);
      addr_mismatch = 1'b0;
      @(negedge core_clk);
      chkb("pin_oe", lock_serial_out_pin_oe, 1'b1);
      chkb("pad_released", pad_released, 1'b0);
      wr(ANALOG_ENABLE_CONTROLS_IDX, ANALOG_ENABLE_CONTROLS_RST & ~24'h000020);
      repeat (3) @(negedge core_clk);
      chkb("pin_oe", lock_serial_out_pin_oe, 1'b0);
      chkb("pin_o", lock_serial_out_pin_o, 1'b0);
      conclude();
   end

   // the run needs well under a thousand cycles
   initial
   begin
      #20000;
      mismatches++;
      conclude();
   end
endmodule

`default_nettype wire
